// >>> core/sdwl_loader.sv
// serial word loader: shift register, dac register and switch decode
`timescale 1ns/100ps
module sdwl_loader
    import sdwl_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // configuration
    input wire logic bipolar_mode,
    input wire logic short_word_mode,
    // serial link pins
    input wire sdwl_pins_t pins,
    // dac outputs
    output sdwl_switch_t switches,
    output logic [WORD_W-1:0] dac_code
);
    // synchronised pin levels
    logic frame_n_s;
    logic sclk_s;
    logic sdata_s;
    logic strobe_n_s;
    logic restore_n_s;

    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] dac_r;
    logic strobe_armed_r;
    logic [WORD_W-1:0] load_word;

    // one-cycle edge pulses
    logic sclk_rise;
    logic frame_rise;
    logic strobe_fall;
    logic restore_fall;
    logic [SEG_N-1:0] therm;
    logic [WORD_W-1:0] dac_nxt;

    // link pins: two flops into this domain, then an edge stage
    sdwl_sync_edge #(.IDLE(1'b1)) u_sync_frame
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in(pins.frame_n),
        .level(frame_n_s),
        .rise(frame_rise),
        .fall()
    );

    sdwl_sync_edge #(.IDLE(1'b1)) u_sync_sclk
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in(pins.sclk),
        .level(sclk_s),
        .rise(sclk_rise),
        .fall()
    );

    sdwl_sync_edge #(.IDLE(1'b1)) u_sync_sdata
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in(pins.sdata),
        .level(sdata_s),
        .rise(),
        .fall()
    );

    // strobe pins
    sdwl_sync_edge #(.IDLE(1'b1)) u_sync_strobe
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in(pins.update_strobe_n),
        .level(strobe_n_s),
        .rise(),
        .fall(strobe_fall)
    );

    sdwl_sync_edge #(.IDLE(1'b1)) u_sync_restore
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in(pins.midscale_restore_n),
        .level(restore_n_s),
        .rise(),
        .fall(restore_fall)
    );

    // shift chain has no reset, contents start undefined
    // extra bits push the oldest out; short frames keep old ones
    always_ff @(posedge clk)
    begin
        if (ce && sclk_rise && !frame_n_s)
        begin
            shift_r <= {shift_r[WORD_W-2:0], sdata_s};
        end
    end

    // 12-bit words sit msb-aligned; low nibble reads zero
    assign load_word = short_word_mode ? {shift_r[LADDER_W-1:0], 4'h0} : shift_r;

    // strobe may load only once a frame has closed since the last strobe load
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strobe_armed_r <= 1'b0;
        end
        else if (ce)
        begin
            if (frame_rise)
            begin
                strobe_armed_r <= 1'b1;
            end
            else if (strobe_fall && restore_n_s)
            begin
                strobe_armed_r <= 1'b0;
            end
        end
    end

    always_comb
    begin
        dac_nxt = dac_r;
        // restore outranks any load in the same cycle
        if (restore_fall)
        begin
            dac_nxt = MIDSCALE_CODE;
        end
        else if (frame_rise && !strobe_n_s && restore_n_s)
        begin
            dac_nxt = load_word;
        end
        else if (strobe_fall && strobe_armed_r && frame_n_s && restore_n_s)
        begin
            dac_nxt = load_word;
        end
    end

    // reset code: midscale 16'h8000 in both unipolar and bipolar mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dac_r <= MIDSCALE_CODE;
        end
        else if (ce)
        begin
            dac_r <= dac_nxt;
        end
    end

    // thermometer: switch k on when top nibble exceeds k
    sdwl_therm #(.IN_W(SEG_BITS), .OUT_N(SEG_N)) u_therm
    (
        .code(dac_nxt[WORD_W-1 -: SEG_BITS]),
        .therm(therm)
    );

    // switch controls follow the next dac code
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            switches.segment_switch_controls <= SEG_MID_CODE;
            switches.ladder_switch_controls <= MIDSCALE_CODE[LADDER_W-1:0];
        end
        else if (ce)
        begin
            switches.segment_switch_controls <= therm;
            switches.ladder_switch_controls <= dac_nxt[LADDER_W-1:0];
        end
    end

    // dac code output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dac_code <= MIDSCALE_CODE;
        end
        else if (ce)
        begin
            dac_code <= dac_nxt;
        end
    end

    logic unused_bip;
    assign unused_bip = bipolar_mode;
endmodule

// two flops bring a pin into the clock domain; a third holds the last level
module sdwl_sync_edge
    import sdwl_pkg::*;
#(
    parameter logic IDLE = 1'b1
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // raw pin
    input wire logic pin_in,
    // synchronised level and its edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // first stage may go metastable; only the second stage reads it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= IDLE;
        end
        else if (ce)
        begin
            meta_r <= pin_in;
        end
    end

    // second stage: the settled level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_r <= IDLE;
        end
        else if (ce)
        begin
            sync_r <= meta_r;
        end
    end

    // reset to the idle level so no false edge follows reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            last_r <= IDLE;
        end
        else if (ce)
        begin
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r && !last_r;
    assign fall = !sync_r && last_r;
endmodule

// thermometer decode of a small code
module sdwl_therm
    import sdwl_pkg::*;
#(
    parameter int IN_W = SEG_BITS,
    parameter int OUT_N = SEG_N
)
(
    // binary code in
    input wire logic [IN_W-1:0] code,
    // one control per segment
    output logic [OUT_N-1:0] therm
);
    // switch k closes once the code passes k
    for (genvar k = 0; k < OUT_N; k++)
    begin : g_seg
        assign therm[k] = (code > IN_W'(k));
    end
endmodule

// >>> core/sdwl_pkg.sv
// package: widths, codes and structs for the serial dac word loader
package sdwl_pkg;
    localparam int WORD_W = 16;
    localparam int SEG_BITS = 4;
    localparam int SEG_N = 15;
    localparam int LADDER_W = 12;
    localparam logic [15:0] MIDSCALE_CODE = 16'h8000;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    // segment controls for the midscale code: top nibble 8 closes eight switches
    localparam logic [14:0] SEG_MID_CODE = 15'h00FF;
    // serial clock limit and the bench clock frequency
    localparam int SCLK_MAX_MHZ = 50;
    localparam int CLK_MHZ = 200;
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdata;
        logic update_strobe_n;
        logic midscale_restore_n;
    } sdwl_pins_t;
    typedef struct packed {
        logic [SEG_N-1:0] segment_switch_controls;
        logic [LADDER_W-1:0] ladder_switch_controls;
    } sdwl_switch_t;
endpackage

// >>> bench/sdwl_host_model.sv
// serial host model
`timescale 1ns/100ps
module sdwl_host_model
    import sdwl_pkg::*;
(
    // bench clock
    input wire logic clk,
    // link pins
    output sdwl_pins_t pins
);
    // half of the 160 ns link clock period, in 5 ns cycles
    localparam int HALF = 16;
    initial pins = 5'h1F;
    // strobe and restore first, then a frame of n bits, msb first
    task automatic send(input logic s, r, input logic [19:0] w, input int n);
        pins.update_strobe_n = s;
        pins.midscale_restore_n = r;
        if (n > 0)
        begin
            repeat (HALF) @(negedge clk);
            pins.frame_n = 1'b0;
        end
        for (int i = n - 1; i >= 0; i--)
        begin
            pins.sclk = 1'b0;
            pins.sdata = w[i];
            repeat (HALF) @(negedge clk);
            pins.sclk = 1'b1;
            repeat (HALF) @(negedge clk);
        end
        if (n > 0)
        begin
            pins.frame_n = 1'b1;
            repeat (HALF) @(negedge clk);
            pins.sclk = 1'b0;
        end
    endtask
    // toggle sclk with the frame closed
    task automatic idle_clocks(input int k);
        for (int i = 0; i < k; i++)
        begin
            pins.sclk = ~pins.sclk;
            repeat (HALF) @(negedge clk);
        end
    endtask
endmodule

// >>> bench/sdwl_loader_sva.sv
// loader assertions
`timescale 1ns/100ps
module sdwl_loader_sva
    import sdwl_pkg::*;
(
    // clock, reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic short_word_mode,
    input wire sdwl_pins_t pins,
    input wire sdwl_switch_t switches,
    input wire logic [WORD_W-1:0] dac_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_mid: assert property ($fell(rst) |-> dac_code == 16'h8000)
        else $error("reset");
    a_seg_therm: assert property ($stable(dac_code) |->
        switches.segment_switch_controls == 15'h7FFF >> (4'hF - dac_code[15:12])) else $error("seg");
    a_ladder_low: assert property ($stable(dac_code) |->
        switches.ladder_switch_controls == dac_code[11:0]) else $error("ladder");
    a_no_early: assert property ($changed(pins) |=> $stable(dac_code) [*2])
        else $error("early");
    a_quiet_hold: assert property ($stable(pins) [*8] |-> $stable(dac_code))
        else $error("drift");
    a_restore_mid: assert property ($fell(pins.midscale_restore_n) |->
        ##[2:8] dac_code == 16'h8000)
        else $error("restore");
    a_restore_gate: assert property (!pins.midscale_restore_n [*8] |-> $stable(dac_code))
        else $error("gate");
    a_short_pad: assert property (short_word_mode && $changed(dac_code) |->
        dac_code[3:0] == 4'h0)
        else $error("pad");
endmodule

// >>> bench/tb_top.sv
// loader bench
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic short_word_mode = 1'b0;
    int errors = 0;
    int n_checks = 0;
    sdwl_pkg::sdwl_pins_t pins;
    sdwl_pkg::sdwl_switch_t switches;
    logic [15:0] dac_code;
    initial forever #2.5 clk = ~clk;
    sdwl_host_model u_host (.clk, .pins);
    sdwl_loader u_dut (.clk, .rst, .ce(1'b1), .bipolar_mode(1'b1), .short_word_mode, .pins,
        .switches, .dac_code);
    task automatic step(input logic s, r, input logic [19:0] w, input int n, input logic [15:0] e);
        logic [15:0] seg_e;
        seg_e = (16'h0001 << e[15:12]) - 16'h0001;
        u_host.send(s, r, w, n);
        repeat (8) @(negedge clk);
        n_checks++;
        if (dac_code !== e || switches.ladder_switch_controls !== e[11:0]
            || switches.segment_switch_controls !== seg_e[14:0])
        begin
            $display("BAD %0t dac %h want %h", $time, dac_code, e);
            errors++;
        end
    endtask
    task automatic report_and_stop(input int late);
        $display("checks %0d errors %0d", n_checks, errors + late);
        if (errors + late == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_sync();
        step(0, 1, 20'h0A5C3, 16, 16'hA5C3);
        u_host.idle_clocks(4);
        step(0, 1, 20'h00000, 4, 16'h5C30);
        step(0, 1, 20'h12345, 20, 16'h2345);
        $display("sync done");
    endtask
    task automatic t_strobe();
        step(1, 1, 20'h01234, 16, 16'h2345);
        step(0, 1, 20'h0, 0, 16'h1234);
        step(0, 0, 20'h0, 0, 16'h8000);
        step(1, 0, 20'h04321, 16, 16'h8000);
        step(0, 0, 20'h0, 0, 16'h8000);
        short_word_mode = 1'b1;
        step(0, 1, 20'h00ABC, 12, 16'hABC0);
        $display("strobe done");
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        step(1, 1, 20'h0, 0, 16'h8000);
        t_sync();
        t_strobe();
        report_and_stop(0);
    end
    initial #100000 report_and_stop(1);
endmodule
bind sdwl_loader sdwl_loader_sva u_sva (.clk, .rst, .short_word_mode, .pins, .switches, .dac_code);
